/* src/dpts_ctrl.sv */
// Purpose: Controller driving one port of the token semaphores of a
//          dual-port RAM: acquire, release, poll and initialise flags.
// Assumes: One clock clock_i; the device answers within the strobe width.
// Notes: Data pins are three signals; data_oe_n_o is low while driving.
`timescale 1ns/100ps

module dpts_ctrl
    import dpts_pkg::*;
#(
    parameter int STROBE_CYC = DPTS_STROBE_CYC,
    parameter int GAP_CYC = DPTS_GAP_CYC
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_i,
    input wire logic [DPTS_IDX_W-1:0] cmd_flag_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic owned_o,
    output logic [DPTS_IDX_W-1:0] addr_o,
    output dpts_ctl_s ctl_o,
    output logic [DPTS_DATA_W-1:0] data_o,
    output logic data_oe_n_o,
    input wire logic [DPTS_DATA_W-1:0] data_i
);
    // ==========================================================
    // Reset release: asynchronous assert, synchronous release.
    logic rst_m_r;
    logic rst_n_r;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    // ==========================================================
    // Read data synchroniser; the device output is asynchronous.
    logic [DPTS_DATA_W-1:0] din_m_r;
    logic [DPTS_DATA_W-1:0] din_s_r;
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            din_m_r <= '0;
            din_s_r <= '0;
        end else begin
            din_m_r <= data_i;
            din_s_r <= din_m_r;
        end
    end

    // ==========================================================
    // State and working registers.
    dpts_state_e state_r;
    dpts_state_e state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    dpts_cmd_e cmd_r;
    logic [DPTS_IDX_W-1:0] idx_r;
    logic [DPTS_IDX_W-1:0] idx_nxt;
    dpts_ctl_s ctl_nxt;
    logic [DPTS_DATA_W-1:0] dout_nxt;
    logic oe_n_nxt;
    logic owned_nxt;

    // Decodes, kept as named wires.
    // A command is taken only while ready is shown, so nothing slips in
    // during the cycles right after reset release.
    wire take = (state_r == DPTS_ST_IDLE) && cmd_ready_o && cmd_valid_i;
    wire cnt_end = (cnt_r == 4'(STROBE_CYC - 1));
    wire gap_end = (cnt_r == 4'(GAP_CYC - 1));
    // A flag is ours only when every sampled lower-lane bit reads zero.
    // Only the lower byte lane is enabled on reads; the upper lane is not
    // driven by the device, so its bits carry no flag value.
    localparam int LOW_W = DPTS_DATA_W / 2;
    wire flag_zero = ~|din_s_r[LOW_W-1:0];
    // Written value sits on bit 0 only; the rest drive zero.
    wire wr_bit = (cmd_r != DPTS_CMD_ACQUIRE);
    wire last_init = (cmd_r == DPTS_CMD_INIT) && (idx_r == DPTS_IDX_LAST);
    wire wr_then_rd = (cmd_r == DPTS_CMD_ACQUIRE);

    // ==========================================================
    // Next-state logic. Every access keeps the array enable high and
    // the token select low; each access ends with all strobes
    // inactive so a following poll sees fresh data.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        idx_nxt = idx_r;
        ctl_nxt = DPTS_CTL_IDLE;
        dout_nxt = '0;
        oe_n_nxt = 1'b1;
        owned_nxt = owned_o;
        case (state_r)
            DPTS_ST_IDLE: begin
                cnt_nxt = DPTS_CNT_ZERO;
                if (take) begin
                    // Init starts from flag 0 and walks all eight.
                    idx_nxt = (cmd_i == DPTS_CMD_INIT) ? '0 : cmd_flag_i;
                    state_nxt = (cmd_i == DPTS_CMD_READ) ?
                        DPTS_ST_RD : DPTS_ST_WR;
                end
            end
            DPTS_ST_WR: begin
                // Write strobe: select low, array enable high.
                ctl_nxt.token_space_select_n = 1'b0;
                ctl_nxt.rw_n = 1'b0;
                ctl_nxt.lower_byte_sel_n = 1'b0;
                dout_nxt = {{(DPTS_DATA_W-1){1'b0}}, wr_bit};
                oe_n_nxt = 1'b0;
                cnt_nxt = cnt_r + DPTS_CNT_ONE;
                if (cnt_end) begin
                    cnt_nxt = DPTS_CNT_ZERO;
                    state_nxt = DPTS_ST_GAP;
                end
            end
            DPTS_ST_GAP: begin
                // Strobes inactive; bus released before any read.
                cnt_nxt = cnt_r + DPTS_CNT_ONE;
                if (gap_end) begin
                    cnt_nxt = DPTS_CNT_ZERO;
                    if (wr_then_rd) begin
                        state_nxt = DPTS_ST_RD;
                    end else if (cmd_r == DPTS_CMD_INIT && !last_init) begin
                        idx_nxt = idx_r + 3'h1;
                        state_nxt = DPTS_ST_WR;
                    end else begin
                        if (cmd_r != DPTS_CMD_READ) begin
                            owned_nxt = 1'b0;
                        end
                        state_nxt = DPTS_ST_DONE;
                    end
                end
            end
            DPTS_ST_RD: begin
                // Read strobe; the device holds its output latched.
                ctl_nxt.token_space_select_n = 1'b0;
                ctl_nxt.output_enable_n = 1'b0;
                ctl_nxt.lower_byte_sel_n = 1'b0;
                cnt_nxt = cnt_r + DPTS_CNT_ONE;
                // Wait two more cycles for the synchroniser.
                if (cnt_r == 4'(STROBE_CYC + 1)) begin
                    cnt_nxt = DPTS_CNT_ZERO;
                    owned_nxt = flag_zero;
                    state_nxt = DPTS_ST_DONE;
                end
            end
            DPTS_ST_DONE: begin
                // One result cycle, strobes idle: a new poll restarts.
                state_nxt = DPTS_ST_IDLE;
            end
            default: begin
                state_nxt = DPTS_ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers; every output is a flip-flop.
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= DPTS_ST_IDLE;
            cnt_r <= DPTS_CNT_ZERO;
            cmd_r <= DPTS_CMD_READ;
            idx_r <= '0;
            ctl_o <= DPTS_CTL_IDLE;
            data_o <= '0;
            data_oe_n_o <= 1'b1;
            owned_o <= 1'b0;
            addr_o <= '0;
            done_o <= 1'b0;
            cmd_ready_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (take) begin
                cmd_r <= dpts_cmd_e'(cmd_i);
            end
            idx_r <= idx_nxt;
            ctl_o <= ctl_nxt;
            data_o <= dout_nxt;
            data_oe_n_o <= oe_n_nxt;
            owned_o <= owned_nxt;
            addr_o <= idx_nxt;
            done_o <= (state_nxt == DPTS_ST_DONE);
            cmd_ready_o <= (state_nxt == DPTS_ST_IDLE);
        end
    end

    // ==========================================================
    // Checks on the driven pins.
    AST_SELECT_NOT_ARRAY: assert property (
        @(posedge clock_i) disable iff (!rst_n_r)
        !ctl_o.token_space_select_n |-> ctl_o.chip_enable_n)
        else $error("Array enable active during token access.");
    AST_WRITE_BIT_ONLY: assert property (
        @(posedge clock_i) disable iff (!rst_n_r)
        !data_oe_n_o |-> (data_o[DPTS_DATA_W-1:1] == '0))
        else $error("Upper data bits driven during token write.");
    AST_NO_DRIVE_ON_READ: assert property (
        @(posedge clock_i) disable iff (!rst_n_r)
        !ctl_o.output_enable_n |-> data_oe_n_o && ctl_o.rw_n)
        else $error("Bus driven while device output enabled.");
    AST_POLL_GAP: assert property (
        @(posedge clock_i) disable iff (!rst_n_r)
        done_o |=> (ctl_o == DPTS_CTL_IDLE))
        else $error("Select still active at end of access.");
    AST_ACQ_READS: assert property (
        @(posedge clock_i) disable iff (!rst_n_r)
        (take && cmd_i == DPTS_CMD_ACQUIRE) |=>
        ##[1:40] !ctl_o.output_enable_n)
        else $error("Acquire did not read back the flag.");
    AST_RELEASE_CLEARS: assert property (
        @(posedge clock_i) disable iff (!rst_n_r)
        (take && cmd_i == DPTS_CMD_RELEASE) |-> ##[1:40] (done_o && !owned_o))
        else $error("Release did not clear ownership.");
    AST_ADDR_STABLE: assert property (
        @(posedge clock_i) disable iff (!rst_n_r)
        (!ctl_o.token_space_select_n && $past(!ctl_o.token_space_select_n))
        |-> $stable(addr_o))
        else $error("Flag address moved during strobe.");
    AST_READY_IDLE: assert property (
        @(posedge clock_i) disable iff (!rst_n_r)
        cmd_ready_o |-> ctl_o == DPTS_CTL_IDLE)
        else $error("Strobes active while idle.");
    COV_ACQ_WON: cover property (@(posedge clock_i)
        done_o && owned_o);
    COV_INIT: cover property (@(posedge clock_i)
        take && cmd_i == DPTS_CMD_INIT);
    COV_ACQ_LOST: cover property (@(posedge clock_i)
        done_o && !owned_o && cmd_r == DPTS_CMD_ACQUIRE);
endmodule

/* src/dpts_pkg.sv */
// Purpose: Shared constants and types for the token semaphore port controller.
// Assumes: One clock at 100 MHz; the device port is asynchronous SRAM-like.
// Notes: Strobe widths are counted in clock cycles of the controller.
package dpts_pkg;
    // ==========================================================
    // Geometry of the token space.
    localparam int DPTS_FLAGS = 8;
    localparam int DPTS_IDX_W = 3;
    localparam int DPTS_DATA_W = 18;
    localparam int DPTS_ADDR_W = 18;
    // ==========================================================
    // Timing: strobe width and settle time, in ns and in cycles.
    localparam int DPTS_CLK_NS = 10;
    localparam int DPTS_STROBE_NS = 30;
    localparam int DPTS_STROBE_CYC =
        (DPTS_STROBE_NS + DPTS_CLK_NS - 1) / DPTS_CLK_NS;
    localparam int DPTS_GAP_NS = 10;
    localparam int DPTS_GAP_CYC =
        (DPTS_GAP_NS + DPTS_CLK_NS - 1) / DPTS_CLK_NS;
    localparam logic [3:0] DPTS_CNT_ZERO = 4'h0;
    localparam logic [3:0] DPTS_CNT_ONE = 4'h1;
    // ==========================================================
    // User command codes.
    typedef enum logic [1:0] {
        DPTS_CMD_ACQUIRE = 2'b00,  // Write zero, then read back.
        DPTS_CMD_RELEASE = 2'b01,  // Write one.
        DPTS_CMD_READ    = 2'b10,  // Read flag only.
        DPTS_CMD_INIT    = 2'b11   // Write one to every flag.
    } dpts_cmd_e;
    // Controller states.
    typedef enum logic [2:0] {
        DPTS_ST_IDLE  = 3'b000,
        DPTS_ST_WR    = 3'b001,
        DPTS_ST_GAP   = 3'b010,
        DPTS_ST_RD    = 3'b011,
        DPTS_ST_DONE  = 3'b100
    } dpts_state_e;
    // Pin group driven to the device port.
    typedef struct packed {
        logic token_space_select_n;
        logic chip_enable_n;
        logic rw_n;
        logic output_enable_n;
        logic lower_byte_sel_n;
        logic upper_byte_sel_n;
    } dpts_ctl_s;
    localparam dpts_ctl_s DPTS_CTL_IDLE = 6'b11_1111;
    localparam logic [DPTS_IDX_W-1:0] DPTS_IDX_LAST = 3'h7;
endpackage

/* verification/dpts_dev_model.sv */
// Purpose: Behavioural model of the device token flags, two ports.
// Assumes: Port A is the controller pins, port B is poked by the bench.
// Notes: An undriven data half shows the inverse of the latched value.
`timescale 1ns/100ps
module dpts_dev_model
    import dpts_pkg::*;
(
    input wire logic [DPTS_IDX_W-1:0] addr_i,
    input wire dpts_ctl_s ctl_i,
    input wire logic [DPTS_DATA_W-1:0] wdata_i,
    input wire logic wdata_oe_n_i,
    input wire logic b_wr_i,
    input wire logic [DPTS_IDX_W-1:0] b_idx_i,
    input wire logic b_val_i,
    output logic [DPTS_DATA_W-1:0] rdata_o,
    output logic [DPTS_FLAGS-1:0] b_flag_o
);
    // ==========================================================
    // Flag state; owner 0 is none, 1 port A, 2 port B. No gating.
    logic [DPTS_FLAGS-1:0] rq [2];
    logic [1:0] own [DPTS_FLAGS];
    logic q; // Port A output latch.
    wire wr_a = !ctl_i.token_space_select_n && !ctl_i.rw_n
        && !wdata_oe_n_i;
    wire rd_a = !ctl_i.token_space_select_n && !ctl_i.output_enable_n
        && !(ctl_i.lower_byte_sel_n && ctl_i.upper_byte_sel_n);
    // Neither enable nor select active: the port stands by, drivers off.
    wire standby_a = ctl_i.token_space_select_n
        && ctl_i.chip_enable_n;
    // Power-up leaves stale requests, so both sides must free them.
    initial begin
        rq[0] = 8'hFF;
        rq[1] = 8'hFF;
        q = 1'b1;
        for (int i = 0; i < DPTS_FLAGS; i++) own[i] = 2'd2;
    end
    // A zero requests, a one withdraws and hands over to a waiter.
    task automatic upd(input int p, input logic [2:0] i, input logic v);
        rq[p][i] = !v;
        // Calls run one at a time, so at most one port is granted.
        if (!v && own[i] == 2'd0) own[i] = 2'(p + 1);
        if (v && own[i] == 2'(p + 1)) begin
            own[i] = rq[1-p][i] ? 2'(2 - p) : 2'd0;
        end
    endtask
    // Data is taken just after the strobe rises, once all pins settled.
    always @(posedge wr_a) begin
        #1;
        upd(0, addr_i, wdata_i[0]);
    end
    always @(posedge b_wr_i) upd(1, b_idx_i, b_val_i);
    // The latch holds while the selects stay active.
    always @(posedge rd_a) q = (own[addr_i] != 2'd1);
    // Byte selects gate the drivers; the latch loads only while either one is active.
    assign rdata_o[8:0] = (rd_a && !standby_a && !ctl_i.lower_byte_sel_n)
        ? {9{q}} : {9{~q}};
    assign rdata_o[17:9] = (rd_a && !standby_a && !ctl_i.upper_byte_sel_n)
        ? {9{q}} : {9{~q}};
    for (genvar g = 0; g < DPTS_FLAGS; g++) begin : g_bview
        assign b_flag_o[g] = (own[g] != 2'd2);
    end
endmodule

/* verification/dual_port_token_semaphores_tb_top.sv */
// Purpose: Self-checking bench for the token semaphore controller.
// Assumes: Default strobe 3 cycles and gap 1 cycle.
// Notes: Port B of the device is worked directly by the bench.
`timescale 1ns/100ps
module dual_port_token_semaphores_tb_top;
    import dpts_pkg::*;
    // ==========================================================
    // Clock, pins and counters.
    localparam int S = 3;
    localparam int G = 1;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic vld = 1'b0;
    logic [1:0] cmd = 2'b00;
    logic [2:0] flg = 3'h0;
    logic b_wr = 1'b0;
    logic [2:0] b_idx = 3'h0;
    logic b_val = 1'b1;
    logic rdy, done, own, doe_n, ce_bad = 1'b0;
    logic [2:0] addr;
    logic [7:0] bf;
    logic [17:0] wd, rd;
    dpts_ctl_s ctl;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    dpts_ctrl #(.STROBE_CYC(S), .GAP_CYC(G)) dpts_ctrl_i (.clock_i(clk),
        .nrst_i(nrst), .cmd_valid_i(vld), .cmd_i(cmd), .cmd_flag_i(flg),
        .cmd_ready_o(rdy), .done_o(done), .owned_o(own), .addr_o(addr),
        .ctl_o(ctl), .data_o(wd), .data_oe_n_o(doe_n), .data_i(rd));
    dpts_dev_model dpts_dev_model_i (.addr_i(addr), .ctl_i(ctl),
        .wdata_i(wd), .wdata_oe_n_i(doe_n), .b_wr_i(b_wr),
        .b_idx_i(b_idx), .b_val_i(b_val), .rdata_o(rd), .b_flag_o(bf));
    // The array enable must never be pulled low in token space.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (nrst && ctl.chip_enable_n !== 1'b1) ce_bad <= 1'b1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (e !== g) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Issue one command and check its latency and the owned result.
    task automatic run(input logic [1:0] c, input logic [2:0] f,
        input int lat, input logic eo);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 100) n_fail++;
        vld = 1'b1;
        cmd = c;
        flg = f;
        @(posedge clk);
        #1 vld = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        chk("latency", lat, n);
        chk("owned", eo, own);
    endtask
    task automatic b_op(input logic [2:0] i, input logic v);
        @(posedge clk);
        #1 b_idx = i;
        b_val = v;
        b_wr = 1'b1;
        @(posedge clk);
        #1 b_wr = 1'b0;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_init();
        for (int i = 0; i < 8; i++) b_op(3'(i), 1'b1);
        run(DPTS_CMD_INIT, 3'h5, 8 * (S + G), 1'b0);
        for (int i = 0; i < 8; i++) b_op(3'(i), 1'b1);
        chk("b_view", 8'hFF, bf);
        $display("test init done");
    endtask
    task automatic t_pass();
        run(DPTS_CMD_ACQUIRE, 3'h3, S + G + S + 2, 1'b1);
        b_op(3'h3, 1'b0);
        chk("b_view", 8'hFF, bf);
        run(DPTS_CMD_READ, 3'h3, S + 2, 1'b1);
        run(DPTS_CMD_RELEASE, 3'h3, S + G, 1'b0);
        chk("b_view", 8'hF7, bf);
        run(DPTS_CMD_ACQUIRE, 3'h3, S + G + S + 2, 1'b0);
        b_op(3'h3, 1'b1);
        run(DPTS_CMD_READ, 3'h3, S + 2, 1'b1);
        run(DPTS_CMD_RELEASE, 3'h3, S + G, 1'b0);
        run(DPTS_CMD_READ, 3'h3, S + 2, 1'b0);
        $display("test pass done");
    endtask
    task automatic t_index();
        for (int f = 0; f < 8; f++) begin
            run(DPTS_CMD_ACQUIRE, 3'(f), S + G + S + 2, 1'b1);
            for (int i = 0; i < 8; i++) b_op(3'(i), 1'b0);
            chk("b_view", 8'h1 << f, bf);
            for (int i = 0; i < 8; i++) b_op(3'(i), 1'b1);
            run(DPTS_CMD_RELEASE, 3'(f), S + G, 1'b0);
        end
        chk("array_enable", 1'b0, ce_bad);
        $display("test index done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        t_init();
        t_pass();
        t_index();
        print_verdict();
    end
endmodule
